// *** shared/cmpa_pkg.sv ***
// Shared constants and carrier types for the core memory port arbiter.
// Assumes a single 125 MHz clock domain and no software registers.
package cmpa_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned NUM_PORTS    = 12;
  localparam int unsigned BASIC_PORTS  = 2;
  localparam int unsigned WORD_W       = 33;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned PARITY_BIT   = 32;
  localparam int unsigned BANK_WORDS   = 16384;
  localparam int unsigned BANK_AW      = 14;
  localparam int unsigned NUM_BANKS    = 4;
  localparam int unsigned BANK_SEL_W   = 2;
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned PORT_IDX_W   = 4;

  // ****************************************************************
  // Address map fields
  // ****************************************************************
  localparam int unsigned BANK_LSB     = 0;
  localparam int unsigned UNIT_LSB     = 1;
  localparam int unsigned ROW_LSB      = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned CYCLE_TIME_NS = 900;
  localparam int unsigned CYCLE_CLKS    =
    (CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W         = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [PORT_IDX_W-1:0] IDX_RST = 4'h0;
  localparam logic [CNT_W-1:0]      CNT_RST = 7'h00;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              high;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cmpa_req_t;

  typedef struct packed {
    logic [BANK_SEL_W-1:0] bank;
    logic [BANK_AW-1:0]    row;
  } cmpa_loc_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_CYCLE = 3'b010,
    ST_DONE  = 3'b100
  } cmpa_state_t;

endpackage

// *** logic/cmpa_bank_mem.sv ***
// Single 16K x 33 core bank with a registered read port.
// Assumes one access at a time, granted by the arbiter above it.
`timescale 1ns/1ps
module cmpa_bank_mem
(
  // Clock
  input  wire logic                            mclk,
  // Access
  input  wire logic                            en,
  input  wire logic                            we,
  input  wire logic [cmpa_pkg::BANK_AW-1:0]    row,
  input  wire logic [cmpa_pkg::WORD_W-1:0]     wword,
  output      logic [cmpa_pkg::WORD_W-1:0]     rword
);

  logic [cmpa_pkg::WORD_W-1:0] mem [cmpa_pkg::BANK_WORDS];

  // Whole-word write and registered read
  always_ff @(posedge mclk)
  begin
    if (en && we)
    begin
      mem[row] <= wword;
    end
    if (en)
    begin
      rword <= mem[row];
    end
  end

endmodule

// *** logic/cmpa_arbiter.sv ***
// Twelve-port arbiter in front of a four-bank core memory store.
// Assumes requesters hold req until their one-cycle done pulse.
`timescale 1ns/1ps
module cmpa_arbiter
(
  // Clock and reset
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  // Port requests
  input  wire logic [cmpa_pkg::NUM_PORTS-1:0] req,
  input  wire cmpa_pkg::cmpa_req_t            req_info [cmpa_pkg::NUM_PORTS],
  // Port answers
  output      logic [cmpa_pkg::NUM_PORTS-1:0] grant_r,
  output      logic [cmpa_pkg::NUM_PORTS-1:0] done_r,
  output      logic [cmpa_pkg::DATA_W-1:0]    rdata_r,
  output      logic                           parity_err_r
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_r;
  logic rst_n_r;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Lowest set bit as one-hot, port 1 is bit 0
  function automatic logic [cmpa_pkg::NUM_PORTS-1:0] first_one
    (input logic [cmpa_pkg::NUM_PORTS-1:0] v);
    logic [cmpa_pkg::NUM_PORTS-1:0] r;
    r = '0;
    for (int i = cmpa_pkg::NUM_PORTS - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // One-hot to index
  function automatic logic [cmpa_pkg::PORT_IDX_W-1:0] to_idx
    (input logic [cmpa_pkg::NUM_PORTS-1:0] v);
    logic [cmpa_pkg::PORT_IDX_W-1:0] r;
    r = cmpa_pkg::IDX_RST;
    for (int i = 0; i < cmpa_pkg::NUM_PORTS; i++)
    begin
      if (v[i])
      begin
        r = cmpa_pkg::PORT_IDX_W'(i);
      end
    end
    return r;
  endfunction

  // Same decode for every port
  function automatic cmpa_pkg::cmpa_loc_t decode
    (input logic [cmpa_pkg::ADDR_W-1:0] a);
    cmpa_pkg::cmpa_loc_t l;
    l.bank = {a[cmpa_pkg::UNIT_LSB], a[cmpa_pkg::BANK_LSB]};
    l.row  = a[cmpa_pkg::ADDR_W-1:cmpa_pkg::ROW_LSB];
    return l;
  endfunction

  // Even parity over the 32 data bits
  function automatic logic par_of(input logic [cmpa_pkg::DATA_W-1:0] d);
    return ^d;
  endfunction

  // ****************************************************************
  // Arrival tracking
  // ****************************************************************
  logic [cmpa_pkg::NUM_PORTS-1:0] req_q_r;
  logic [cmpa_pkg::NUM_PORTS-1:0] fresh;
  logic [cmpa_pkg::NUM_PORTS-1:0] waiting;
  logic [cmpa_pkg::NUM_PORTS-1:0] hi_vec;

  // Per-port high-level flags
  genvar g;
  generate
    for (g = 0; g < cmpa_pkg::NUM_PORTS; g++)
    begin : g_hi
      assign hi_vec[g] = req[g] && req_info[g].high;
    end
  endgenerate

  // ****************************************************************
  // Grant state machine
  // ****************************************************************
  cmpa_pkg::cmpa_state_t            state_r;
  cmpa_pkg::cmpa_state_t            state_nxt;
  logic [cmpa_pkg::NUM_PORTS-1:0]   grant_nxt;
  logic [cmpa_pkg::NUM_PORTS-1:0]   done_nxt;
  logic [cmpa_pkg::PORT_IDX_W-1:0]  sel_r;
  logic [cmpa_pkg::PORT_IDX_W-1:0]  sel_nxt;
  logic [cmpa_pkg::CNT_W-1:0]       cnt_r;
  logic [cmpa_pkg::CNT_W-1:0]       cnt_nxt;
  logic [cmpa_pkg::NUM_PORTS-1:0]   pool;
  logic [cmpa_pkg::NUM_PORTS-1:0]   win;
  logic                             mem_en;
  cmpa_pkg::cmpa_req_t              cur;
  cmpa_pkg::cmpa_loc_t              loc;

  assign cur = req_info[sel_r];
  assign loc = decode(cur.addr);

  // Choose winner and step the cycle
  always_comb
  begin
    fresh     = req & ~req_q_r; // First seen at this edge
    waiting   = req & ~fresh;   // Already seen one edge earlier
    state_nxt = state_r;
    grant_nxt = grant_r;
    done_nxt  = '0;
    sel_nxt   = sel_r;
    cnt_nxt   = cnt_r;
    mem_en    = 1'b0;
    // Waiting requests outrank newcomers
    pool = (waiting != '0) ? waiting : req;
    // High level outranks normal, then lowest number
    if ((pool & hi_vec) != '0)
    begin
      win = first_one(pool & hi_vec);
    end
    else
    begin
      win = first_one(pool);
    end
    unique case (state_r)
      cmpa_pkg::ST_IDLE:
      begin
        if (req != '0)
        begin
          grant_nxt = win;
          sel_nxt   = to_idx(win);
          cnt_nxt   = cmpa_pkg::CNT_RST;
          state_nxt = cmpa_pkg::ST_CYCLE;
        end
      end
      cmpa_pkg::ST_CYCLE:
      begin
        cnt_nxt = cnt_r + 1'b1;
        mem_en  = (cnt_r == cmpa_pkg::CNT_RST);
        if (cnt_r == cmpa_pkg::CNT_W'(cmpa_pkg::CYCLE_CLKS - 1))
        begin
          done_nxt  = grant_r;
          grant_nxt = '0;
          state_nxt = cmpa_pkg::ST_DONE;
        end
      end
      cmpa_pkg::ST_DONE:
      begin
        // Served port drops its req during this cycle
        state_nxt = cmpa_pkg::ST_IDLE;
      end
    endcase
  end

  // Register grant state
  always_ff @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= cmpa_pkg::ST_IDLE;
      grant_r <= '0;
      done_r  <= '0;
      sel_r   <= cmpa_pkg::IDX_RST;
      cnt_r   <= cmpa_pkg::CNT_RST;
      req_q_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      grant_r <= grant_nxt;
      done_r  <= done_nxt;
      sel_r   <= sel_nxt;
      cnt_r   <= cnt_nxt;
      req_q_r <= req;
    end
  end

  // ****************************************************************
  // Banks
  // ****************************************************************
  logic [cmpa_pkg::WORD_W-1:0] bank_rd [cmpa_pkg::NUM_BANKS];
  logic [cmpa_pkg::WORD_W-1:0] wword;
  logic [cmpa_pkg::BANK_SEL_W-1:0] rd_bank_r;
  logic [cmpa_pkg::BANK_SEL_W-1:0] rd_bank_nxt;

  assign wword = {par_of(cur.wdata), cur.wdata};

  // Four independent 16K banks
  generate
    for (g = 0; g < cmpa_pkg::NUM_BANKS; g++)
    begin : g_bank
      cmpa_bank_mem u_bank
      (
        .mclk  (mclk),
        .en    (mem_en && (loc.bank == cmpa_pkg::BANK_SEL_W'(g))),
        .we    (cur.write),
        .row   (loc.row),
        .wword (wword),
        .rword (bank_rd[g])
      );
    end
  endgenerate

  // Read data and parity check on completion
  logic [cmpa_pkg::DATA_W-1:0] rdata_nxt;
  logic                        perr_nxt;
  logic [cmpa_pkg::WORD_W-1:0] rw;

  always_comb
  begin
    rw        = bank_rd[rd_bank_r];
    rdata_nxt = rdata_r;
    perr_nxt  = parity_err_r;
    rd_bank_nxt = mem_en ? loc.bank : rd_bank_r;
    if (done_nxt != '0)
    begin
      rdata_nxt = cur.write ? '0 : rw[cmpa_pkg::DATA_W-1:0];
      perr_nxt  = !cur.write &&
                  (rw[cmpa_pkg::PARITY_BIT] != par_of(rdata_nxt));
    end
  end

  // Register read answer
  always_ff @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rdata_r      <= '0;
      parity_err_r <= 1'b0;
      rd_bank_r    <= '0;
    end
    else
    begin
      rdata_r      <= rdata_nxt;
      parity_err_r <= perr_nxt;
      rd_bank_r    <= rd_bank_nxt;
    end
  end

endmodule

// *** tb/cmpa_arbiter_sva.sv ***
// Checker on the arbiter ports: grants and done pulses.
// Assumes requesters hold req until their done pulse.
`timescale 1ns/1ps
module cmpa_arbiter_sva
(
  // Clock and reset
  input wire logic                mclk,
  input wire logic                reset_n,
  // Requests and answers
  input wire logic [11:0]         req,
  input wire cmpa_pkg::cmpa_req_t req_info [12],
  input wire logic [11:0]         grant_r,
  input wire logic [11:0]         done_r
);
  // ****************
  // Expected winner
  // ****************
  logic [11:0] r1_r, r2_r, h1_r;
  logic [11:0] pool, pick, win;
  // Request history for arrival order
  always_ff @(posedge mclk)
  begin
    r1_r <= req;
    r2_r <= r1_r;
    for (int i = 0; i < 12; i++)
      h1_r[i] <= req_info[i].high;
  end
  // Old waiters, then high level, then lowest port
  always_comb
  begin
    pool = ((r1_r & r2_r) != 0) ? (r1_r & r2_r) : r1_r;
    pick = ((pool & h1_r) != 0) ? (pool & h1_r) : pool;
    win = pick & (~pick + 12'h001);
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence s_start;
    $rose(|grant_r);
  endsequence
  sequence s_finish;
    (done_r == $past(grant_r)) && (grant_r == 0);
  endsequence
  grant_single_a: assert property ($onehot0(grant_r))
    else $error("two grants at once");
  done_single_a: assert property (
    $onehot0(done_r) && !(|(done_r & grant_r)))
    else $error("bad done vector");
  winner_pick_a: assert property (
    s_start |-> grant_r == win)
    else $error("wrong port granted");
  grant_span_a: assert property (
    s_start |-> ##113 s_finish)
    else $error("cycle length wrong");
  grant_hold_a: assert property (
    |grant_r |=> grant_r == 0 || $stable(grant_r))
    else $error("grant moved mid cycle");
  grant_owner_a: assert property (
    |grant_r |-> (grant_r & req) == grant_r)
    else $error("grant without request");
  prompt_take_a: assert property (
    grant_r == 0 && done_r == 0 && $past(done_r) == 0 && req != 0
    |=> grant_r != 0)
    else $error("idle request not taken");
  done_pulse_a: assert property (
    |done_r |=> done_r == 0 && grant_r == 0)
    else $error("done longer than one cycle");
endmodule

bind cmpa_arbiter cmpa_arbiter_sva u_sva
(
  .mclk(mclk), .reset_n(reset_n), .req(req), .req_info(req_info),
  .grant_r(grant_r), .done_r(done_r)
);

// *** tb/cmpa_req_model.sv ***
// Behavioural requesters on the twelve memory buses.
// Assumes the bench pulses start for one cycle per request.
`timescale 1ns/1ps
module cmpa_req_model
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                reset_n,
  // Bench commands
  input  wire logic [11:0]         start,
  input  wire cmpa_pkg::cmpa_req_t cmd [12],
  // Arbiter side
  input  wire logic [11:0]         done_r,
  output      logic [11:0]         req,
  output      cmpa_pkg::cmpa_req_t req_info [12]
);
  logic [11:0] pend_r;
  // Pending set: raised on start, dropped at done
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pend_r <= 12'h000;
    else
      pend_r <= (pend_r | start) & ~done_r;
  end
  // Hold request until done; idle info shows inverted junk
  always_comb
  begin
    req = pend_r & ~done_r;
    for (int i = 0; i < 12; i++)
      req_info[i] = pend_r[i] ? cmd[i] : ~cmd[i];
  end
endmodule

// *** tb/cmpa_arbiter_test.sv ***
// Bench for the twelve-port arbiter with the requester model.
// Assumes the checker is bound to the arbiter.
`timescale 1ns/1ps
module cmpa_arbiter_test;
  logic                mclk;
  logic                reset_n;
  logic [11:0]         start;
  cmpa_pkg::cmpa_req_t cmd [12];
  logic [11:0]         req;
  cmpa_pkg::cmpa_req_t req_info [12];
  logic [11:0]         grant_r;
  logic [11:0]         done_r;
  logic [31:0]         rdata_r;
  logic                parity_err_r;
  int                  err_count;
  int                  comparisons;

  // Requesters and arbiter
  cmpa_req_model u_req (.mclk(mclk), .reset_n(reset_n), .start(start),
    .cmd(cmd), .done_r(done_r), .req(req), .req_info(req_info));
  cmpa_arbiter uut (.mclk(mclk), .reset_n(reset_n), .req(req),
    .req_info(req_info), .grant_r(grant_r), .done_r(done_r),
    .rdata_r(rdata_r), .parity_err_r(parity_err_r));

  // 125 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Data pattern tied to the address
  function automatic logic [31:0] pat(input logic [15:0] a);
    return {a ^ 16'h5a5a, ~a};
  endfunction

  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t port vector %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t read data %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Queue one request on port p, numbered from 1
  task automatic put(input int p, input logic hi, input logic wr,
                     input logic [15:0] a);
    cmd[p-1] = '{hi, wr, a, pat(a)};
    start[p-1] = 1'b1;
  endtask

  // Present the queued requests for one cycle
  task automatic fire();
    @(negedge mclk);
    start = 12'h000;
  endtask

  // Wait, bounded, for the next done pulse and judge it
  task automatic next_done(input int p, input logic [31:0] d);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (done_r === 12'h000 && n < 400);
    chk12(done_r, 12'h001 << (p - 1));
    chk32(rdata_r, d);
    chk12({11'h000, parity_err_r}, 12'h000);
    if (n >= 400)
      tally_and_finish();
  endtask

  // Four simultaneous writes, one per bank
  task automatic t_write_all();
    for (int p = 1; p <= 4; p++)
      put(p, 1'b0, 1'b1, 16'(p - 1));
    fire();
    @(negedge mclk);
    chk12(grant_r, 12'h001);
    for (int p = 1; p <= 4; p++)
      next_done(p, 32'h0000_0000);
  endtask

  // Far ports read back in reverse address order
  task automatic t_read_tie();
    for (int p = 9; p <= 12; p++)
      put(p, 1'b0, 1'b0, 16'(12 - p));
    fire();
    for (int p = 9; p <= 12; p++)
      next_done(p, pat(16'(12 - p)));
  endtask

  // High level beats port 1
  task automatic t_high();
    put(1, 1'b0, 1'b0, 16'h0001);
    put(9, 1'b1, 1'b0, 16'h0002);
    put(11, 1'b1, 1'b0, 16'h0003);
    fire();
    next_done(9, pat(16'h0002));
    next_done(11, pat(16'h0003));
    next_done(1, pat(16'h0001));
  endtask

  // Waiting port 7 beats newcomer port 1
  task automatic t_arrival();
    put(12, 1'b0, 1'b0, 16'h0000);
    fire();
    repeat (20) @(negedge mclk);
    put(7, 1'b0, 1'b0, 16'h0002);
    fire();
    next_done(12, pat(16'h0000));
    put(1, 1'b0, 1'b0, 16'h0001);
    fire();
    next_done(7, pat(16'h0002));
    next_done(1, pat(16'h0001));
  endtask

  // Reset, then the scenarios
  initial
  begin
    err_count = 0;
    comparisons = 0;
    reset_n = 1'b0;
    start = 12'h000;
    cmd = '{default: '0};
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_write_all();
    t_read_tie();
    t_high();
    t_arrival();
    tally_and_finish();
  end
endmodule
